// ===== spc_chk.sv
`timescale 1ns/100ps
// ========
// port checks
module spc_chk(
	input wire ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
	input wire s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
	input wire s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire sckOut, sckOeN, mosiOeN, misoOeN,
	input wire [31:0] s_axi_rdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_wTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_bAns;
		s_wTaken |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_bAns: assert property (p_bAns) else $error("write answer late");
	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer dropped");
	property p_rAns;
		s_rTaken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rAns: assert property (p_rAns) else $error("read answer wrong");
	property p_rHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read answer moved");
	property p_rdyLow;
		(!s_axi_bvalid || !s_axi_awready && !s_axi_wready) && (!s_axi_rvalid || !s_axi_arready);
	endproperty
	a_rdyLow: assert property (p_rdyLow) else $error("ready while answering");
	property p_roleOe;
		sckOeN == mosiOeN && (sckOeN || misoOeN);
	endproperty
	a_roleOe: assert property (p_roleOe) else $error("pin drive mix");
	// toggles every five cycles, so four quiet samples follow each change
	property p_sckHalf;
		!sckOeN && $past(!sckOeN) && $changed(sckOut) |=> $stable(sckOut) [*4];
	endproperty
	a_sckHalf: assert property (p_sckHalf) else $error("clock half short");
	property p_rst;
		disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && sckOeN && misoOeN;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind spc_spi_config_status spc_chk i_spc_chk(.ref_clk(ref_clk), .srst(srst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sckOut(sckOut),
	.sckOeN(sckOeN), .mosiOeN(mosiOeN), .misoOeN(misoOeN), .s_axi_rdata(s_axi_rdata));

// ===== spc_deglitch.v
`timescale 1ns/100ps
`include "spc_map.vh"
module spc_deglitch #(
	parameter STABLE = `SPC_DGL_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// synchronised level in, filtered level out
	input wire levelIn,
	output wire levelOut
);
	// ==========================================
	// filter: a new level must hold STABLE cycles before it is passed on
	reg [7:0] cnt_q;
	reg level_q;
	always @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= 8'h00;
			level_q <= 1'b1;
		end else if (levelIn == level_q) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == STABLE[7:0] - 8'h01) begin
			cnt_q <= 8'h00;
			level_q <= levelIn;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	assign levelOut = level_q;
endmodule

// ===== spc_map.vh
// Function
// - busy flag at bit 7 is one throughout any transfer, either role
// - bit 6 zero selects target role, one selects controller driving SCK
// - phase bit 5: data centred on first SCK edge if zero, second if one
// - polarity bit 4 zero: SCK rests low when no transfer runs
// - polarity bit one: SCK rests high when no transfer runs
// - selected flag at bit 3 reflects de-glitched select input, one when low
// - bit 2 returns the unfiltered select pin level when read
// - target shift-empty flag set when idle, cleared on load or SCK edge; one as controller
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// ==========================================
// register map
`define SPC_CFG_INDEX 12'h0A1
`define SPC_CFG_ADDR 12'h284
`define SPC_DATA_ADDR 12'h000
`define SPC_CFG_RESET 8'h07
`define SPC_CFG_WMASK 8'h70
// ==========================================
// configuration bit positions
`define SPC_BIT_BUSY 7
`define SPC_BIT_ROLE 6
`define SPC_BIT_PHASE 5
`define SPC_BIT_POL 4
`define SPC_BIT_SEL 3
`define SPC_BIT_NSS 2
`define SPC_BIT_SHIFT_EMPTY_FLAG 1
`define SPC_BIT_RXMT 0
// ==========================================
// timing counts: ref_clk cycles, and SCK edges per byte
`define SPC_HALF_CYC 5
`define SPC_DGL_CYC 4
`define SPC_EDGES 16
// ==========================================
// bus answers
`define SPC_RESP_OKAY 2'h0
`define SPC_RESP_SLVERR 2'h2
`endif

// ===== spc_peer.sv
`timescale 1ns/100ps
// ========
// far-side target for controller traffic
module spc_peer(
	input wire sck, mosi, ph, arm,
	input wire [7:0] txb,
	output logic miso,
	output logic [7:0] rxb
);
	int n;
	logic [7:0] sh;
	logic armed = 0;
	// one process owns every output; the rise of arm restarts the byte
	always @(sck or arm) begin
		if (!arm) armed = 0;
		else if (!armed) begin
			armed = 1;
			n = 0;
			sh = ph ? txb : txb << 1;
			miso = ph ? !txb[0] : txb[7];
		end else begin
			// sample on even edges in phase 0, odd in phase 1
			if (n % 2 == ph) rxb = {rxb[6:0], mosi};
			else begin
				miso = sh[7];
				sh = sh << 1;
			end
			n++;
		end
	end
endmodule

// ===== spc_spi_config_status.v
`timescale 1ns/100ps
`include "spc_map.vh"
module spc_spi_config_status #(
	parameter HALF_CYC = `SPC_HALF_CYC,
	parameter DGL_CYC = `SPC_DGL_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// serial clock, output enable low while driven
	input wire sckIn,
	output reg sckOut,
	output wire sckOeN,
	// controller-out data line
	input wire mosiIn,
	output wire mosiOut,
	output wire mosiOeN,
	// target-out data line
	input wire misoIn,
	output wire misoOut,
	output wire misoOeN,
	// select input, active low
	input wire nssN
);
	// ==========================================
	// helpers
	// true when edge index e is a sampling edge for the given phase
	function isSample;
		input [3:0] e;
		input phase;
		begin
			isSample = (e[0] == phase);
		end
	endfunction
	// true when edge index e moves the next bit out
	function isShift;
		input [3:0] e;
		input phase;
		begin
			isShift = (e[0] != phase) && !(phase ? (e == 4'h0) : (e == 4'hF));
		end
	endfunction

	// ==========================================
	// pin synchronisers
	wire sckS;
	wire mosiS;
	wire misoS;
	wire nssS;
	wire nssFilt;
	spc_sync #(.WIDTH(4)) uSync (
		.ref_clk(ref_clk),
		.srst(srst),
		.asyncIn({sckIn, mosiIn, misoIn, nssN}),
		.syncOut({sckS, mosiS, misoS, nssS})
	);
	spc_deglitch #(.STABLE(DGL_CYC)) uDgl (
		.ref_clk(ref_clk),
		.srst(srst),
		.levelIn(nssS),
		.levelOut(nssFilt)
	);

	// ==========================================
	// configuration and data state
	reg role_q;
	reg phase_q;
	reg pol_q;
	reg [7:0] txBuf_q;
	reg txFull_q;
	reg [7:0] rxBuf_q;
	reg rxFull_q;
	reg [7:0] txSh_q;
	reg [7:0] rxSh_q;
	reg [3:0] edgeCnt_q;
	reg mBusy_q;
	reg [7:0] divCnt_q;
	reg sckPrev_q;
	reg shLoaded_q;
	wire selected = !nssFilt;
	wire busy = role_q ? mBusy_q : (edgeCnt_q != 4'h0);
	wire shift_empty_flag = role_q ? 1'b1 : (!shLoaded_q && edgeCnt_q == 4'h0 && !txFull_q);
	wire rxmt = role_q ? 1'b1 : !rxFull_q;
	wire [7:0] cfgRead = {busy, role_q, phase_q, pol_q, selected, nssS, shift_empty_flag, rxmt};

	// ==========================================
	// axi4-lite slave: address and data taken in either order
	reg [11:0] awAddr_q;
	reg awHave_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg wHave_q;
	assign s_axi_awready = !awHave_q && !s_axi_bvalid;
	assign s_axi_wready = !wHave_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire wrGo = awHave_q && wHave_q && !s_axi_bvalid;
	wire wrCfg = wrGo && awAddr_q == `SPC_CFG_ADDR && wStrb_q[0];
	wire wrData = wrGo && awAddr_q == `SPC_DATA_ADDR && wStrb_q[0];
	wire rdGo = s_axi_arvalid && !s_axi_rvalid;
	wire rdData = rdGo && s_axi_araddr == `SPC_DATA_ADDR;

	always @(posedge ref_clk) begin
		if (srst) begin
			awAddr_q <= 12'h000;
			awHave_q <= 1'b0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			wHave_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHave_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHave_q <= 1'b1;
			end
			if (wrGo) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awAddr_q == `SPC_CFG_ADDR || awAddr_q == `SPC_DATA_ADDR) begin
					s_axi_bresp <= `SPC_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SPC_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SPC_RESP_OKAY;
		end else if (rdGo) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SPC_RESP_OKAY;
			if (s_axi_araddr == `SPC_CFG_ADDR) begin
				s_axi_rdata <= {24'h000000, cfgRead};
			end else if (s_axi_araddr == `SPC_DATA_ADDR) begin
				s_axi_rdata <= {24'h000000, rxBuf_q};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `SPC_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// configuration register; status bits are computed, so writes cannot reach them
	always @(posedge ref_clk) begin
		if (srst) begin
			role_q <= 1'b0;
			phase_q <= 1'b0;
			pol_q <= 1'b0;
		end else if (wrCfg) begin
			role_q <= wData_q[`SPC_BIT_ROLE];
			phase_q <= wData_q[`SPC_BIT_PHASE];
			pol_q <= wData_q[`SPC_BIT_POL];
		end
	end

	// ==========================================
	// shift engine
	// target edges come from the synchronised clock, so the peer's SCK must stay
	// well below a quarter of ref_clk
	wire sEdge = !role_q && selected && (sckS != sckPrev_q);
	wire mTick = role_q && mBusy_q && (divCnt_q == HALF_CYC[7:0] - 8'h01);
	wire anyEdge = sEdge || mTick;
	wire lastEdge = anyEdge && edgeCnt_q == 4'hF;
	wire mStart = role_q && !mBusy_q && txFull_q;
	wire sLoad = !role_q && txFull_q && !shLoaded_q && edgeCnt_q == 4'h0;
	wire bitIn = role_q ? misoS : mosiS;

	always @(posedge ref_clk) begin
		if (srst) begin
			txBuf_q <= 8'h00;
			txFull_q <= 1'b0;
			rxBuf_q <= 8'h00;
			rxFull_q <= 1'b0;
			txSh_q <= 8'h00;
			rxSh_q <= 8'h00;
			edgeCnt_q <= 4'h0;
			mBusy_q <= 1'b0;
			divCnt_q <= 8'h00;
			sckPrev_q <= 1'b0;
			shLoaded_q <= 1'b0;
			sckOut <= 1'b0;
		end else begin
			sckPrev_q <= sckS;
			// a write to a full transmit buffer is dropped
			if (wrData && !txFull_q) begin
				txBuf_q <= wData_q[7:0];
				txFull_q <= 1'b1;
			end else if (mStart || sLoad) begin
				txFull_q <= 1'b0;
			end
			if (mStart || sLoad) begin
				txSh_q <= txBuf_q;
				shLoaded_q <= 1'b1;
			end
			if (mStart) begin
				mBusy_q <= 1'b1;
				divCnt_q <= 8'h00;
			end else if (mBusy_q) begin
				divCnt_q <= mTick ? 8'h00 : divCnt_q + 8'h01;
			end
			// sck level: rests at polarity, toggles only while a transfer runs
			if (!role_q || !mBusy_q) begin
				sckOut <= pol_q;
			end else if (mTick) begin
				sckOut <= !sckOut;
			end
			if (anyEdge) begin
				edgeCnt_q <= edgeCnt_q + 4'h1;
				if (isSample(edgeCnt_q, phase_q)) begin
					rxSh_q <= {rxSh_q[6:0], bitIn};
				end
				if (isShift(edgeCnt_q, phase_q)) begin
					txSh_q <= {txSh_q[6:0], 1'b0};
				end
			end
			if (lastEdge) begin
				mBusy_q <= 1'b0;
				shLoaded_q <= 1'b0;
				rxBuf_q <= isSample(edgeCnt_q, phase_q) ? {rxSh_q[6:0], bitIn} : rxSh_q;
				rxFull_q <= 1'b1;
			end else if (rdData) begin
				rxFull_q <= 1'b0;
			end
			// deselect mid-byte aborts the target's partial byte
			if (!role_q && !selected && !sEdge) begin
				edgeCnt_q <= 4'h0;
			end
			// a role change abandons any transfer in flight
			if (wrCfg && wData_q[`SPC_BIT_ROLE] != role_q) begin
				mBusy_q <= 1'b0;
				edgeCnt_q <= 4'h0;
				shLoaded_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// pin drive
	assign sckOeN = !role_q;
	assign mosiOut = txSh_q[7];
	assign mosiOeN = !role_q;
	assign misoOut = txSh_q[7];
	assign misoOeN = !(!role_q && selected);
endmodule

// ===== spc_sync.v
`timescale 1ns/100ps
module spc_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// asynchronous in, synchronised out
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	// ==========================================
	// two stages; the first stage feeds only the second
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;
	always @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= asyncIn;
			sync_q <= meta_q;
		end
	end
	assign syncOut = sync_q;
endmodule

// ===== test_spi_config_status.sv
`timescale 1ns/100ps
`include "spc_map.vh"
module test_spi_config_status;
	logic ref_clk = 0, srst = 1, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
	logic [11:0] awA = 0, arA = 0;
	logic [31:0] wD = 0, v;
	logic bSck = 0, bMosi = 0, nssN = 1, ph = 0, arm = 0;
	logic [7:0] pTx = 0, got, d;
	logic [1:0] r;
	wire awRdy, wRdy, bV, arRdy, rV, sckO, sckE, mosiO, mosiE, misoO, misoE, pMiso;
	wire [1:0] bResp, rResp;
	wire [31:0] rD;
	wire [7:0] pRx;
	// the bench stands in on any line the design lets go
	wire sckW = sckE ? bSck : sckO;
	wire mosiW = mosiE ? bMosi : mosiO;
	wire misoW = misoE ? pMiso : misoO;
	int badCount = 0, totalChecks = 0, k;
	initial forever #2.5 ref_clk = !ref_clk;
	spc_spi_config_status i_spc_spi_config_status(.ref_clk(ref_clk), .srst(srst),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
		.s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
		.s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR),
		.s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
		.s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
		.sckIn(sckW), .sckOut(sckO), .sckOeN(sckE), .mosiIn(mosiW), .mosiOut(mosiO),
		.mosiOeN(mosiE), .misoIn(misoW), .misoOut(misoO), .misoOeN(misoE), .nssN(nssN));
	spc_peer i_spc_peer(.sck(sckW), .mosi(mosiW), .ph(ph), .arm(arm), .txb(pTx),
		.miso(pMiso), .rxb(pRx));
	// ========
	// checking and closing
	task automatic endSim;
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		totalChecks++;
		if (s !== e) begin
			badCount++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tmo(input int j);
		if (j >= 60) begin
			badCount++;
			endSim;
		end
	endtask
	// ========
	// bus cycles; ready comes a cycle late so held answers get exercised
	task automatic wr(input logic [11:0] a, input logic [7:0] x);
		int j;
		@(posedge ref_clk);
		awA <= a;
		wD <= {24'h0, x};
		awV <= 1;
		wV <= 1;
		for (j = 0; j < 60; j++) begin
			@(posedge ref_clk);
			if (awRdy) awV <= 0;
			if (wRdy) wV <= 0;
			if (bV && bR) break;
			bR <= j > 1;
		end
		r = bResp;
		bR <= 0;
		tmo(j);
	endtask
	task automatic rd(input logic [11:0] a);
		int j;
		@(posedge ref_clk);
		arA <= a;
		arV <= 1;
		for (j = 0; j < 60; j++) begin
			@(posedge ref_clk);
			if (arRdy) arV <= 0;
			if (rV && rR) break;
			rR <= j > 0;
		end
		v = rD;
		r = rResp;
		rR <= 0;
		tmo(j);
	endtask
	task automatic cfg(input logic [7:0] e);
		rd(`SPC_CFG_ADDR);
		chk("config", v, {24'h0, e});
	endtask
	// bench as controller with phase p and polarity q, off the clock grid
	task automatic frame(input logic [7:0] b, input logic p, q);
		#0.5;
		for (int i = 7; i >= 0; i--) begin
			if (!p) bMosi = b[i];
			#24 bSck = !q;
			if (p) bMosi = b[i];
			else got = {got[6:0], misoW};
			#24 bSck = q;
			if (p) got = {got[6:0], misoW};
		end
	endtask
	// ========
	// tests
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 0;
		repeat (4) @(posedge ref_clk);
		cfg(8'h07);
		wr(`SPC_CFG_ADDR, 8'hFF);
		cfg(8'h77);
		wr(12'h010, 8'h55);
		chk("bresp", r, `SPC_RESP_SLVERR);
		rd(12'h010);
		chk("rresp", r, `SPC_RESP_SLVERR);
		chk("rdata", v, 32'h0);
		$display("test registers done");
		for (int m = 0; m < 4; m++) begin
			d = 8'hA5 ^ {4{m[1:0]}};
			ph <= m[1];
			wr(`SPC_CFG_ADDR, {2'b01, m[1:0], 4'h0});
			// peer byte settles a cycle before arm so the peer never races it
			pTx <= ~d;
			@(posedge ref_clk);
			chk("idle", sckW, m[0]);
			arm <= 1;
			wr(`SPC_DATA_ADDR, d);
			rd(`SPC_CFG_ADDR);
			chk("busy", v[7], 1);
			for (k = 0; k < 60 && v[7] === 1'b1; k++) rd(`SPC_CFG_ADDR);
			tmo(k);
			chk("rest", sckW, m[0]);
			chk("peer", pRx, d);
			rd(`SPC_DATA_ADDR);
			chk("rx", v, {24'h0, ~d});
			arm <= 0;
		end
		$display("test controller done");
		wr(`SPC_CFG_ADDR, 8'h00);
		nssN <= 0;
		repeat (10) @(posedge ref_clk);
		// a two-cycle blip must not deselect
		nssN <= 1;
		repeat (2) @(posedge ref_clk);
		nssN <= 0;
		repeat (4) @(posedge ref_clk);
		cfg(8'h0B);
		wr(`SPC_DATA_ADDR, 8'h3C);
		rd(`SPC_CFG_ADDR);
		chk("load", v[1], 0);
		fork
			frame(8'hC3, 0, 0);
			begin
				repeat (30) @(posedge ref_clk);
				rd(`SPC_CFG_ADDR);
				chk("busy", v[7], 1);
			end
		join
		repeat (4) @(posedge ref_clk);
		cfg(8'h0A);
		chk("miso", got, 8'h3C);
		rd(`SPC_DATA_ADDR);
		chk("target rx", v, 32'hC3);
		// deselect before moving the idle level so no false edge is counted
		nssN <= 1;
		repeat (10) @(posedge ref_clk);
		bSck <= 1;
		wr(`SPC_CFG_ADDR, 8'h30);
		cfg(8'h37);
		nssN <= 0;
		repeat (10) @(posedge ref_clk);
		wr(`SPC_DATA_ADDR, 8'h96);
		frame(8'h69, 1, 1);
		repeat (4) @(posedge ref_clk);
		cfg(8'h3A);
		chk("miso", got, 8'h96);
		rd(`SPC_DATA_ADDR);
		chk("target rx", v, 32'h69);
		$display("test target done");
		endSim;
	end
endmodule
